/* File: shared/ioport_regs.svh */
`ifndef IOPORT_REGS_SVH
`define IOPORT_REGS_SVH

`define PORT_A_VALUE_IDX     16'h0000
`define PORT_A_DIRECTION_IDX 16'h0001
`define PORT_A_OPTION_IDX    16'h0002
`define PORT_B_VALUE_IDX     16'h0003
`define PORT_B_DIRECTION_IDX 16'h0004
`define PORT_B_OPTION_IDX    16'h0005
`define PORT_C_VALUE_IDX     16'h0006
`define PORT_C_DIRECTION_IDX 16'h0007
`define PORT_C_OPTION_IDX    16'h0008
`define PORT_D_VALUE_IDX     16'h0009
`define PORT_D_DIRECTION_IDX 16'h000a
`define PORT_D_OPTION_IDX    16'h000b
`define PORT_E_VALUE_IDX     16'h000c
`define PORT_E_DIRECTION_IDX 16'h000d
`define PORT_E_OPTION_IDX    16'h000e
`define STATUS_IDX           16'h007f

`define PORT_STRIDE    3
`define FIELD_VALUE    2'h0
`define FIELD_DIR      2'h1
`define FIELD_OPT      2'h2
`define PORT_RESET     8'h00

`define ADDR_SPACE_BYTES 65536
`define REG_AREA_FIRST 16'h0000
`define REG_AREA_LAST  16'h007f
`define RAM_FIRST      16'h0080
`define RAM_LAST       16'h087f
`define STACK_FIRST    16'h0100
`define STACK_LAST     16'h01ff
`define PROG_FIRST     16'h1000
`define VECTOR_FIRST   16'hffe0

`define RESP_OKAY      2'h0
`define RESP_DECERR    2'h3

`endif

/* File: shared/ioport_pkg.sv */
package ioport_pkg;
  typedef enum logic [2:0] {
    REGION_REGS,
    REGION_RAM,
    REGION_STACK,
    REGION_PROGRAM,
    REGION_VECTORS,
    REGION_RESERVED
  } region_t;

  typedef struct packed {
    logic       hit;
    logic [2:0] port;
    logic [1:0] field;
  } reg_sel_t;
endpackage : ioport_pkg

/* File: shared/decode_if.sv */
`timescale 1ns/10ps
interface decode_if;
  logic [15:0]         cpu_addr;
  ioport_pkg::region_t region;

  modport requester (output cpu_addr, input region);
  modport decoder   (input cpu_addr, output region);
endinterface : decode_if

/* File: rtl/region_decode.sv */
`timescale 1ns/10ps
`include "ioport_regs.svh"
module region_decode (
  // address in, region out
  decode_if.decoder dec
);
  // vectors checked first: they sit inside the program window
  always_comb begin
    dec.region = ioport_pkg::REGION_RESERVED;
    if (dec.cpu_addr >= `VECTOR_FIRST) begin
      dec.region = ioport_pkg::REGION_VECTORS;
    end else if (dec.cpu_addr >= `PROG_FIRST) begin
      dec.region = ioport_pkg::REGION_PROGRAM;
    end else if (dec.cpu_addr >= `STACK_FIRST && dec.cpu_addr <= `STACK_LAST) begin
      dec.region = ioport_pkg::REGION_STACK;
    end else if (dec.cpu_addr <= `REG_AREA_LAST) begin
      dec.region = ioport_pkg::REGION_REGS;
    end else if (dec.cpu_addr >= `RAM_FIRST && dec.cpu_addr <= `RAM_LAST) begin
      dec.region = ioport_pkg::REGION_RAM;
    end
  end
endmodule : region_decode

/* File: rtl/io_port_register_map.sv */
`timescale 1ns/10ps
`include "ioport_regs.svh"
module io_port_register_map #(
  parameter int                       NUM_PORTS   = 5,
  parameter logic [NUM_PORTS*8-1:0]   UNBONDED    = '0,
  parameter logic [NUM_PORTS*8-1:0]   INT_PINS    = 40'h00_d3_06_00_00,
  parameter logic [NUM_PORTS*8-1:0]   INT_PULLUP  = 40'h00_41_02_00_00,
  parameter logic [NUM_PORTS*2-1:0]   INT_VECTOR  = 10'h0e4,
  parameter int                       CAN_PORT    = 2,
  parameter int                       CAN_BIT     = 4
) (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write address and data
  input  wire logic [17:0]                   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output wire logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output wire logic                          s_axi_wready,
  // axi4-lite write response
  output wire logic [1:0]                    s_axi_bresp,
  output wire logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read
  input  wire logic [17:0]                   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output wire logic                          s_axi_arready,
  output wire logic [31:0]                   s_axi_rdata,
  output wire logic [1:0]                    s_axi_rresp,
  output wire logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // pads
  input  wire logic [NUM_PORTS-1:0][7:0]     pad_in,
  output wire logic [NUM_PORTS-1:0][7:0]     pad_out,
  output wire logic [NUM_PORTS-1:0][7:0]     pad_oe,
  output wire logic [NUM_PORTS-1:0][7:0]     pad_pullup,
  output wire logic [NUM_PORTS-1:0][7:0]     pad_int_en,
  // can transmit pin
  input  wire logic                          can_tx_data,
  input  wire logic                          can_tx_en,
  // external interrupt requests, one per vector
  output wire logic [3:0]                    ext_int_req
);

  logic [NUM_PORTS-1:0][7:0] val_ff;
  logic [NUM_PORTS-1:0][7:0] dir_ff;
  logic [NUM_PORTS-1:0][7:0] opt_ff;
  logic [NUM_PORTS-1:0][7:0] pad_out_ff;
  logic [NUM_PORTS-1:0][7:0] pad_oe_ff;
  logic [NUM_PORTS-1:0][7:0] pad_pullup_ff;
  logic [NUM_PORTS-1:0][7:0] pad_int_en_ff;
  logic [3:0]                ext_int_req_ff;
  logic                      awready_ff;
  logic                      wready_ff;
  logic                      aw_got_ff;
  logic                      w_got_ff;
  logic [15:0]               aw_addr_ff;
  logic [7:0]                w_data_ff;
  logic                      w_strb_ff;
  logic                      bvalid_ff;
  logic [1:0]                bresp_ff;
  logic                      arready_ff;
  logic                      rd_pend_ff;
  logic [15:0]               ar_addr_ff;
  logic                      rvalid_ff;
  logic [31:0]               rdata_ff;
  logic [1:0]                rresp_ff;
  ioport_pkg::region_t       last_region_ff;
  logic                      do_write;
  ioport_pkg::reg_sel_t      wr_sel;
  ioport_pkg::reg_sel_t      rd_sel;

  decode_if wr_dec ();
  decode_if rd_dec ();

  region_decode u_wr_decode (.dec(wr_dec.decoder));
  region_decode u_rd_decode (.dec(rd_dec.decoder));

  // byte address is four times the register index
  assign wr_dec.cpu_addr = aw_addr_ff;
  assign rd_dec.cpu_addr = ar_addr_ff;

  // index to port and field; stride of three per port
  function automatic ioport_pkg::reg_sel_t reg_sel(input logic [15:0] idx);
    ioport_pkg::reg_sel_t s;
    s = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int f = 0; f < `PORT_STRIDE; f++) begin
        if (idx == 16'(`PORT_A_VALUE_IDX + p * `PORT_STRIDE + f)) begin
          s.hit   = 1'b1;
          s.port  = 3'(p);
          s.field = 2'(f);
        end
      end
    end
    return s;
  endfunction : reg_sel

  assign wr_sel   = reg_sel(aw_addr_ff);
  assign rd_sel   = reg_sel(ar_addr_ff);
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= 16'h0000;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_got_ff  <= 1'b1;
      aw_addr_ff <= s_axi_awaddr[17:2];
    end else if (do_write) begin
      aw_got_ff  <= 1'b0;
    end else if (!aw_got_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  // write data channel; registers live in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      w_data_ff <= 8'h00;
      w_strb_ff <= 1'b0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_got_ff  <= 1'b1;
      w_data_ff <= s_axi_wdata[7:0];
      w_strb_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_got_ff  <= 1'b0;
    end else if (!w_got_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  // write response; outside the register area the answer is DECERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_dec.region == ioport_pkg::REGION_REGS) ? `RESP_OKAY : `RESP_DECERR;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // port registers; misses in the register area are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      val_ff <= {NUM_PORTS{`PORT_RESET}};
      dir_ff <= {NUM_PORTS{`PORT_RESET}};
      opt_ff <= {NUM_PORTS{`PORT_RESET}};
    end else if (do_write && w_strb_ff && wr_sel.hit
                 && wr_dec.region == ioport_pkg::REGION_REGS) begin
      unique case (wr_sel.field)
        `FIELD_VALUE: val_ff[wr_sel.port] <= w_data_ff;
        `FIELD_DIR:   dir_ff[wr_sel.port] <= w_data_ff;
        default:      opt_ff[wr_sel.port] <= w_data_ff;
      endcase
    end
  end

  // last decoded region, visible in the status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_region_ff <= ioport_pkg::REGION_REGS;
    end else if (do_write) begin
      last_region_ff <= wr_dec.region;
    end else if (rd_pend_ff) begin
      last_region_ff <= rd_dec.region;
    end
  end

  // read address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      ar_addr_ff <= 16'h0000;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rd_pend_ff <= 1'b1;
      ar_addr_ff <= s_axi_araddr[17:2];
    end else if (rd_pend_ff) begin
      rd_pend_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // read data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `RESP_OKAY;
    end else if (rd_pend_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
      if (rd_dec.region != ioport_pkg::REGION_REGS) begin
        rresp_ff <= `RESP_DECERR;
      end else if (rd_sel.hit) begin
        unique case (rd_sel.field)
          `FIELD_VALUE: rdata_ff <= {24'h000000, val_ff[rd_sel.port]};
          `FIELD_DIR:   rdata_ff <= {24'h000000, dir_ff[rd_sel.port]};
          default:      rdata_ff <= {24'h000000, opt_ff[rd_sel.port]};
        endcase
      end else if (ar_addr_ff == `STATUS_IDX) begin
        rdata_ff <= {29'h00000000, 3'(last_region_ff)};
      end
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // pad drive; the can pin output follows only the can transmitter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_ff    <= '0;
      pad_oe_ff     <= '0;
      pad_pullup_ff <= UNBONDED;
      pad_int_en_ff <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int b = 0; b < 8; b++) begin
          pad_out_ff[p][b] <= val_ff[p][b];
          pad_oe_ff[p][b]  <= dir_ff[p][b];
          // merged pins pull up, other interrupt pins float
          pad_pullup_ff[p][b] <= !dir_ff[p][b] && (UNBONDED[p*8+b]
                                 || (opt_ff[p][b] && (!INT_PINS[p*8+b]
                                 || INT_PULLUP[p*8+b])));
          pad_int_en_ff[p][b] <= !dir_ff[p][b] && opt_ff[p][b]
                                 && INT_PINS[p*8+b];
          if (p == CAN_PORT && b == CAN_BIT) begin
            pad_out_ff[p][b] <= can_tx_data;
            pad_oe_ff[p][b]  <= can_tx_en;
          end
        end
      end
    end
  end

  // each interrupt pin feeds the vector fixed for its port; active low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_int_req_ff <= 4'h0;
    end else begin
      ext_int_req_ff <= 4'h0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int b = 0; b < 8; b++) begin
          if (pad_int_en_ff[p][b] && !pad_in[p][b]) begin
            ext_int_req_ff[INT_VECTOR[p*2 +: 2]] <= 1'b1;
          end
        end
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign pad_out       = pad_out_ff;
  assign pad_oe        = pad_oe_ff;
  assign pad_pullup    = pad_pullup_ff;
  assign pad_int_en    = pad_int_en_ff;
  assign ext_int_req   = ext_int_req_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_clears_regs_a: assert property (
    !$past(aresetn) |-> (val_ff == '0 && dir_ff == '0 && opt_ff == '0))
    else $error("port registers not zero after reset");

  reg_area_size_a: assert property (
    wr_dec.region == ioport_pkg::REGION_REGS |-> aw_addr_ff < 16'h0080)
    else $error("register area wider than 128 bytes");

  stack_window_a: assert property (
    rd_dec.region == ioport_pkg::REGION_STACK
      |-> (ar_addr_ff >= 16'h0100 && ar_addr_ff <= 16'h01ff))
    else $error("stack decoded outside 0100h-01ffh");

  top_vectors_a: assert property (
    wr_dec.cpu_addr >= 16'hffe0 |-> wr_dec.region == ioport_pkg::REGION_VECTORS)
    else $error("top bytes not decoded as vectors");

  port_e_option_a: assert property (
    do_write && w_strb_ff && aw_addr_ff == 16'h000e
      |=> opt_ff[4] == $past(w_data_ff) && val_ff[4] == $past(val_ff[4]))
    else $error("port e option write misplaced");

  port_a_readback_a: assert property (
    rd_pend_ff && ar_addr_ff == 16'h0001 |=> rvalid_ff && rdata_ff == {24'h0, $past(dir_ff[0])})
    else $error("port a direction read wrong");

  unmapped_zero_a: assert property (
    rd_pend_ff && rd_dec.region == ioport_pkg::REGION_REGS && !rd_sel.hit
      && ar_addr_ff != 16'h007f |=> rvalid_ff && rdata_ff == 32'h0)
    else $error("unmapped register read not zero");

  can_output_a: assert property (
    aresetn |=> pad_oe_ff[CAN_PORT][CAN_BIT] == $past(can_tx_en)
             && pad_out_ff[CAN_PORT][CAN_BIT] == $past(can_tx_data))
    else $error("can pin output not from can transmitter");

  float_int_a: assert property (
    !dir_ff[3][1] && opt_ff[3][1] && !UNBONDED[25]
      |=> pad_int_en_ff[3][1] && !pad_pullup_ff[3][1])
    else $error("floating interrupt pin misconfigured");

  read_latency_a: assert property (
    s_axi_arvalid && arready_ff |-> ##2 rvalid_ff)
    else $error("read answer not two cycles after address");

  write_port_c_c: cover property (do_write && aw_addr_ff == 16'h0006 && w_strb_ff);
  read_stack_c:   cover property (rd_pend_ff && rd_dec.region == ioport_pkg::REGION_STACK);
  can_drive_c:    cover property (pad_oe_ff[CAN_PORT][CAN_BIT]);
  int_request_c:  cover property (ext_int_req_ff[3]);
endmodule : io_port_register_map

/* File: testbench/cpu_core_model.sv */
`timescale 1ns/10ps
module cpu_core_model (
  // clock
  input  wire logic        aclk,
  // write channels
  output logic [17:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read channels
  output logic [17:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    s_axi_awaddr  = 18'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 18'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
  end

  // one byte per word on lane 0; address and data offered together
  task automatic write(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s,
                       output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : write

  task automatic read(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : read
endmodule : cpu_core_model

/* File: testbench/test_io_port_register_map.sv */
`timescale 1ns/10ps
`include "ioport_regs.svh"
module test_io_port_register_map;
  // one unbonded pad, port e bit 7
  localparam logic [39:0] UNB = 40'h80_00_00_00_00;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [17:0]      awaddr, araddr;
  logic [31:0]      wdata, rdata;
  logic [3:0]       wstrb, ext_int_req;
  logic [1:0]       bresp, rresp;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready;
  logic [4:0][7:0]  pad_in = 40'hff_ff_ff_ff_ff;
  logic [4:0][7:0]  pad_out, pad_oe, pad_pullup, pad_int_en;
  logic             can_tx_data = 1'b0;
  logic             can_tx_en = 1'b0;
  int               failures = 0;
  int               comparisons = 0;

  always #2 aclk = ~aclk;

  io_port_register_map #(.UNBONDED(UNB)) io_port_register_map_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .pad_int_en(pad_int_en), .can_tx_data(can_tx_data),
    .can_tx_en(can_tx_en), .ext_int_req(ext_int_req));

  cpu_core_model cpu_core_model_inst (
    .aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
    logic [1:0] r;
    cpu_core_model_inst.write({a, 2'h0}, d, s, r);
    chk("bresp", {38'h0, `RESP_OKAY}, {38'h0, r});
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    cpu_core_model_inst.read({a, 2'h0}, d, r);
    chk("rresp", {38'h0, `RESP_OKAY}, {38'h0, r});
    chk("rdata", {32'h0, e}, {8'h0, d});
  endtask : reg_rd

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : do_reset

  task automatic test_reset;
    for (int i = 0; i <= `PORT_E_OPTION_IDX; i++) reg_rd(i[15:0], `PORT_RESET);
    chk("pad_pullup", UNB, pad_pullup);
    chk("pad_oe", 40'h0, pad_oe);
  endtask : test_reset

  // bit 7 never set, so the unbonded pad keeps its reset setup
  task automatic test_map;
    for (int i = 0; i <= `PORT_E_OPTION_IDX; i++) reg_wr(i[15:0], 8'(i * 8 + 1), 4'h1);
    for (int i = 0; i <= `PORT_E_OPTION_IDX; i++) reg_rd(i[15:0], 8'(i * 8 + 1));
  endtask : test_map

  task automatic test_unmapped;
    reg_wr(16'h000f, 8'hff, 4'h1);
    reg_wr(16'h007e, 8'hff, 4'h1);
    reg_rd(16'h000f, 8'h00);
    reg_rd(16'h007e, 8'h00);
    reg_rd(`PORT_E_OPTION_IDX, 8'h71);
    reg_wr(`PORT_A_VALUE_IDX, 8'hee, 4'h0);
    reg_rd(`PORT_A_VALUE_IDX, 8'h01);
  endtask : test_unmapped

  // only documented regions, none reserved
  task automatic test_regions;
    logic [15:0] adr[8] = '{16'h007f, 16'h0080, 16'h0100, 16'h01ff, 16'h0200, 16'h1000,
                            16'hffdf, 16'hffff};
    logic [1:0]  exp[8] = '{`RESP_OKAY, `RESP_DECERR, `RESP_DECERR, `RESP_DECERR,
                            `RESP_DECERR, `RESP_DECERR, `RESP_DECERR, `RESP_DECERR};
    ioport_pkg::region_t rgn[8] = '{ioport_pkg::REGION_REGS, ioport_pkg::REGION_RAM,
                                    ioport_pkg::REGION_STACK, ioport_pkg::REGION_STACK,
                                    ioport_pkg::REGION_RAM, ioport_pkg::REGION_PROGRAM,
                                    ioport_pkg::REGION_PROGRAM, ioport_pkg::REGION_VECTORS};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++) begin
      cpu_core_model_inst.read({adr[i], 2'h0}, d, r);
      chk("region rresp", {38'h0, exp[i]}, {38'h0, r});
      cpu_core_model_inst.write({adr[i], 2'h0}, 8'h5a, 4'h1, r);
      chk("region bresp", {38'h0, exp[i]}, {38'h0, r});
      // status shows the region of the write just done
      reg_rd(`STATUS_IDX, 8'(rgn[i]));
    end
    reg_rd(`PORT_A_VALUE_IDX, 8'h01);
  endtask : test_regions

  task automatic test_pads;
    reg_wr(`PORT_A_DIRECTION_IDX, 8'hff, 4'h1);
    reg_wr(`PORT_A_VALUE_IDX, 8'ha5, 4'h1);
    reg_wr(`PORT_C_DIRECTION_IDX, 8'hff, 4'h1);
    reg_wr(`PORT_C_VALUE_IDX, 8'hff, 4'h1);
    repeat (3) @(posedge aclk);
    chk("port a oe", 40'hff, {32'h0, pad_oe[0]});
    chk("port a out", 40'ha5, {32'h0, pad_out[0]});
    chk("port c oe", 40'hef, {32'h0, pad_oe[2]});
    chk("port c out", 40'hef, {32'h0, pad_out[2]});
    can_tx_en   <= 1'b1;
    can_tx_data <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("can oe", 40'hff, {32'h0, pad_oe[2]});
    chk("can out", 40'hff, {32'h0, pad_out[2]});
    // transmitter idle again, so a later reset sees the pin released
    can_tx_en   <= 1'b0;
    can_tx_data <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("can oe off", 40'hef, {32'h0, pad_oe[2]});
    chk("can out off", 40'hef, {32'h0, pad_out[2]});
  endtask : test_pads

  task automatic test_irq;
    reg_wr(`PORT_D_DIRECTION_IDX, 8'h00, 4'h1);
    reg_wr(`PORT_D_OPTION_IDX, 8'h87, 4'h1);
    repeat (3) @(posedge aclk);
    chk("port d pullup", 40'h05, {32'h0, pad_pullup[3]});
    chk("port d int", 40'h83, {32'h0, pad_int_en[3]});
    pad_in[3] <= 8'h7f;
    repeat (4) @(posedge aclk);
    chk("irq low", 40'h8, {36'h0, ext_int_req});
    pad_in[3] <= 8'hff;
    repeat (4) @(posedge aclk);
    chk("irq high", 40'h0, {36'h0, ext_int_req});
  endtask : test_irq

  task automatic results;
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  initial begin
    do_reset();
    test_reset();
    test_map();
    test_unmapped();
    test_regions();
    test_pads();
    test_irq();
    do_reset();
    test_reset();
    results();
  end

  initial begin
    #80000;
    failures++;
    results();
  end
endmodule : test_io_port_register_map
